/* File: core/cct_defs.vh */
// constants for the dual capture/compare block with timer routing
// assumes a 32-bit apb bus with word-aligned registers
`ifndef CCT_DEFS_VH
`define CCT_DEFS_VH

// -----------------------------------------
// register byte offsets
// -----------------------------------------
`define CCT_OFF_TSEL   12'h000
`define CCT_OFF_CTL1   12'h004
`define CCT_OFF_VAL1   12'h008
`define CCT_OFF_CTL2   12'h00c
`define CCT_OFF_VAL2   12'h010
`define CCT_OFF_STAT   12'h014
`define CCT_OFF_IEN    12'h018

// -----------------------------------------
// reset values
// -----------------------------------------
`define CCT_RST_TSEL   8'h00
`define CCT_RST_CTL    4'h0
`define CCT_RST_VAL    16'h0000

// -----------------------------------------
// timer selector fields and codes
// -----------------------------------------
`define CCT_TSEL_U1    1:0
`define CCT_TSEL_U2    3:2
`define CCT_TSEL_P3    5:4
`define CCT_TSEL_P4    7:6
`define CCT_TMR_A      2'h0
`define CCT_TMR_B      2'h1
`define CCT_TMR_C      2'h2

// -----------------------------------------
// mode field codes
// -----------------------------------------
`define CCT_M_OFF      4'h0
`define CCT_M_TOGGLE   4'h2
`define CCT_M_CAP_FALL 4'h4
`define CCT_M_CAP_RISE 4'h5
`define CCT_M_CAP_4TH  4'h6
`define CCT_M_CAP_16TH 4'h7
`define CCT_M_SET      4'h8
`define CCT_M_CLEAR    4'h9
`define CCT_M_SWINT    4'ha
`define CCT_M_TRIG     4'hb

// -----------------------------------------
// status register fields
// -----------------------------------------
`define CCT_ST_FLAG    1:0
`define CCT_ST_CMPOUT  3:2

`endif

/* File: core/cct_sync.v */
// two-flop synchroniser for pin levels
// assumes the input is asynchronous to clock
`default_nettype none

module cct_sync #(
  parameter WIDTH = 2
) (
  input  wire             clock,
  input  wire             resetn,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // cct_sync

`default_nettype wire

/* File: core/cct_capture.v */
// capture edge qualifier with prescaler for one unit
// assumes pin_level is already synchronised to clock
`default_nettype none
`include "cct_defs.vh"

module cct_capture (
  input  wire       clock,
  input  wire       resetn,
  input  wire [3:0] mode,
  input  wire       pin_level,
  output wire       cap_event
);

  reg       prev_reg;
  reg [3:0] psc_reg;
  reg [3:0] psc_next;
  wire      is_cap;
  wire      rise;
  wire      fall;

  assign is_cap = (mode[3:2] == 2'h1);
  assign rise   = pin_level & ~prev_reg;
  assign fall   = ~pin_level & prev_reg;

  // qualifying event per mode; every 4th uses the low two bits only
  assign cap_event = is_cap & (
    ((mode == `CCT_M_CAP_FALL) & fall) |
    ((mode == `CCT_M_CAP_RISE) & rise) |
    ((mode == `CCT_M_CAP_4TH) & rise & (psc_reg[1:0] == 2'h3)) |
    ((mode == `CCT_M_CAP_16TH) & rise & (psc_reg == 4'hf)));

  // prescaler: held clear outside capture, kept across capture modes
  always @* begin
    psc_next = psc_reg;
    if (!is_cap) begin
      psc_next = 4'h0;
    end else if (rise) begin
      psc_next = psc_reg + 4'h1;
    end
  end

  // watch the real pin level, so a port write can trigger too
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prev_reg <= 1'b0;
      psc_reg  <= 4'h0;
    end else begin
      prev_reg <= pin_level;
      psc_reg  <= psc_next;
    end
  end

endmodule // cct_capture

`default_nettype wire

/* File: core/cct_top.v */
// two capture/compare units plus the period timer routing register
// assumes an apb master on clock, a shared 16-bit counter on clock
// that pulses counter_tick on each of its own clock edges, and raw pins
//
// Operation
// - four 2-bit timer selectors, 11 reserved
// - each unit routes its own selected timer
// - capture copies full 16-bit counter
// - capture on fall, rise, 4th, 16th rise
// - capture sets flag, software clears
// - new capture overwrites old value
// - edge detector watches actual pin level
// - prescaler cleared when off or reset
// - capture mode change keeps prescaler count
// - capture keeps working during sleep
// - compare every cycle, act per mode
// - every compare match sets the flag
// - zero control write clears compare latch
// - mode 1010 flags only, pin untouched
// - mode 1011 resets counter, starts conversion
// - trigger immediate, reset on counter edge
// - trigger reset never sets overflow flag
// - lost match skips the counter reset
// - compare inactive while asleep
`default_nettype none
`include "cct_defs.vh"

module cct_top #(
  parameter CNT_W = 16
) (
  input  wire             clock,
  input  wire             resetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  input  wire [CNT_W-1:0] wide_counter,
  input  wire             counter_tick,
  input  wire             sleep,
  input  wire             adc_enabled,
  input  wire [2:0]       period_tick,
  input  wire [1:0]       pin_in,
  output reg  [1:0]       pin_out,
  output reg  [1:0]       pin_oe,
  output reg              conv_trigger,
  output reg              counter_reset,
  output reg  [3:0]       unit_timebase
);

  // -----------------------------------------
  // registers and wires
  // -----------------------------------------
  reg  [7:0]       tsel_reg;
  reg  [3:0]       ctl_reg    [0:1];
  reg  [CNT_W-1:0] val_reg    [0:1];
  reg  [1:0]       flag_reg;
  reg  [1:0]       ien_reg;
  reg  [1:0]       match_prev_reg;
  reg  [1:0]       pend_reg;
  reg  [1:0]       flag_next;
  reg  [31:0]      rd_next;
  reg              hit_next;
  wire [1:0]       pin_sync;
  wire [1:0]       cap_event;
  wire [1:0]       match;
  wire [1:0]       match_rise;
  wire [1:0]       trig_rise;
  wire [1:0]       reset_fire;
  wire             setup;
  wire             wr_ok;
  integer          i;
  integer          j;

  // -----------------------------------------
  // helper functions
  // -----------------------------------------

  // pick one period timer tick; reserved code routes nothing
  function route_tick;
    input [1:0] sel;
    input [2:0] ticks;
    begin
      case (sel)
        `CCT_TMR_A: route_tick = ticks[0];
        `CCT_TMR_B: route_tick = ticks[1];
        `CCT_TMR_C: route_tick = ticks[2];
        default:    route_tick = 1'b0;
      endcase
    end
  endfunction

  // compare modes that own the pin
  function drives_pin;
    input [3:0] m;
    begin
      drives_pin = (m == `CCT_M_TOGGLE) | (m == `CCT_M_SET) |
                   (m == `CCT_M_CLEAR);
    end
  endfunction

  // any compare mode, including flag-only and trigger
  function is_cmp;
    input [3:0] m;
    begin
      is_cmp = drives_pin(m) | (m == `CCT_M_SWINT) |
               (m == `CCT_M_TRIG);
    end
  endfunction

  // -----------------------------------------
  // pin synchronisers and capture qualifiers
  // -----------------------------------------
  cct_sync #(
    .WIDTH (2)
  ) u_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // capture logic runs on clock alone, so it keeps going in sleep
  cct_capture u_cap1 (
    .clock     (clock),
    .resetn    (resetn),
    .mode      (ctl_reg[0]),
    .pin_level (pin_sync[0]),
    .cap_event (cap_event[0])
  );

  cct_capture u_cap2 (
    .clock     (clock),
    .resetn    (resetn),
    .mode      (ctl_reg[1]),
    .pin_level (pin_sync[1]),
    .cap_event (cap_event[1])
  );

  // -----------------------------------------
  // compare match detection
  // -----------------------------------------

  // sleep stands for the stopped system clock: no matches then
  // the counter is held for many clocks, so only the match start acts
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cmp
      assign match[g] = is_cmp(ctl_reg[g]) & ~sleep &
                        (wide_counter == val_reg[g]);
      assign match_rise[g] = match[g] & ~match_prev_reg[g];
      assign trig_rise[g]  = match_rise[g] & (ctl_reg[g] == `CCT_M_TRIG);
      // reset only if the match still holds at the counter edge
      assign reset_fire[g] = pend_reg[g] & counter_tick & match[g];
    end
  endgenerate

  // -----------------------------------------
  // apb decode
  // -----------------------------------------
  // register map, one aligned word each, data in the low bits:
  //   0x00 timer selectors, two bits per unit
  //   0x04 / 0x0c control of unit one / unit two, mode in bits 3:0
  //   0x08 / 0x10 value of unit one / unit two, 16 bits
  //   0x14 status: event flags 1:0 write-one-to-clear, latches 3:2
  //   0x18 event enable bits, storage only
  // unmapped words answer with pslverr and read as zero

  assign setup = psel & ~penable;
  assign wr_ok = psel & penable & pready & pwrite;

  // read mux and address check, evaluated in the setup cycle
  always @* begin
    rd_next  = 32'h0000_0000;
    hit_next = 1'b1;
    case (paddr)
      `CCT_OFF_TSEL: rd_next[7:0] = tsel_reg;
      `CCT_OFF_CTL1: rd_next[3:0] = ctl_reg[0];
      `CCT_OFF_VAL1: rd_next[15:0] = val_reg[0];
      `CCT_OFF_CTL2: rd_next[3:0] = ctl_reg[1];
      `CCT_OFF_VAL2: rd_next[15:0] = val_reg[1];
      `CCT_OFF_STAT: rd_next[3:0] = {pin_out, flag_reg};
      `CCT_OFF_IEN:  rd_next[1:0] = ien_reg;
      default:       hit_next = 1'b0;
    endcase
  end

  // one wait-free access phase: pready rises right after setup
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_next;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_next;
      end
    end
  end

  // -----------------------------------------
  // event flags: hardware set wins over a write-one clear
  // -----------------------------------------
  always @* begin
    flag_next = flag_reg;
    if (wr_ok && paddr == `CCT_OFF_STAT) begin
      flag_next = flag_reg & ~pwdata[1:0];
    end
    flag_next = flag_next | cap_event | match_rise;
  end

  // -----------------------------------------
  // software registers, capture loads and compare state
  // -----------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tsel_reg       <= `CCT_RST_TSEL;
      ien_reg        <= 2'h0;
      flag_reg       <= 2'h0;
      match_prev_reg <= 2'h0;
      pend_reg       <= 2'h0;
      for (i = 0; i < 2; i = i + 1) begin
        ctl_reg[i] <= `CCT_RST_CTL;
        val_reg[i] <= `CCT_RST_VAL;
      end
    end else begin
      flag_reg       <= flag_next;
      match_prev_reg <= match;
      if (wr_ok && paddr == `CCT_OFF_TSEL) begin
        tsel_reg <= pwdata[7:0];
      end
      // enable is only held for software; no interrupt line here
      if (wr_ok && paddr == `CCT_OFF_IEN) begin
        ien_reg <= pwdata[1:0];
      end
      if (wr_ok && paddr == `CCT_OFF_CTL1) begin
        ctl_reg[0] <= pwdata[3:0];
      end
      if (wr_ok && paddr == `CCT_OFF_CTL2) begin
        ctl_reg[1] <= pwdata[3:0];
      end
      if (wr_ok && paddr == `CCT_OFF_VAL1) begin
        val_reg[0] <= pwdata[15:0];
      end
      if (wr_ok && paddr == `CCT_OFF_VAL2) begin
        val_reg[1] <= pwdata[15:0];
      end
      for (i = 0; i < 2; i = i + 1) begin
        // a capture beats a same-cycle software write to the value
        if (cap_event[i]) begin
          val_reg[i] <= wide_counter;
        end
        // pending counter reset waits for the counter's own edge
        if (ctl_reg[i] != `CCT_M_TRIG || counter_tick) begin
          pend_reg[i] <= 1'b0;
        end else if (trig_rise[i]) begin
          pend_reg[i] <= 1'b1;
        end
      end
    end
  end

  // -----------------------------------------
  // pin latches and drive enables
  // -----------------------------------------

  // drive enable follows the mode alone; flag-only and trigger
  // modes leave the pin to the port logic
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_oe <= 2'h0;
    end else begin
      pin_oe[0] <= drives_pin(ctl_reg[0]);
      pin_oe[1] <= drives_pin(ctl_reg[1]);
    end
  end

  // off mode clears the latch only; general port data lives elsewhere
  // the latch keeps its level across compare mode changes, so a user
  // who wants a known start writes zero to the control first
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_out <= 2'h0;
    end else begin
      for (j = 0; j < 2; j = j + 1) begin
        if (ctl_reg[j] == `CCT_M_OFF) begin
          pin_out[j] <= 1'b0;
        end else if (match_rise[j]) begin
          case (ctl_reg[j])
            `CCT_M_TOGGLE: pin_out[j] <= ~pin_out[j];
            `CCT_M_SET:    pin_out[j] <= 1'b1;
            `CCT_M_CLEAR:  pin_out[j] <= 1'b0;
            default:       pin_out[j] <= pin_out[j];
          endcase
        end
      end
    end
  end

  // -----------------------------------------
  // converter trigger and counter reset
  // -----------------------------------------

  // trigger goes out on the match start, one register stage late;
  // the reset is a dedicated strobe, not a wrap, so no overflow flag
  // limitation: the strobe lands one clock after the counter edge, so
  // the counter shows one count past the match for that clock
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_trigger  <= 1'b0;
      counter_reset <= 1'b0;
    end else begin
      conv_trigger  <= |trig_rise & adc_enabled;
      counter_reset <= |reset_fire;
    end
  end

  // -----------------------------------------
  // period timer routing
  // -----------------------------------------

  // each unit follows only its own selector
  // a reserved code routes no tick but stays stored and readable
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      unit_timebase <= 4'h0;
    end else begin
      unit_timebase[0] <= route_tick(tsel_reg[`CCT_TSEL_U1], period_tick);
      unit_timebase[1] <= route_tick(tsel_reg[`CCT_TSEL_U2], period_tick);
      unit_timebase[2] <= route_tick(tsel_reg[`CCT_TSEL_P3], period_tick);
      unit_timebase[3] <= route_tick(tsel_reg[`CCT_TSEL_P4], period_tick);
    end
  end

endmodule // cct_top

`default_nettype wire

/* File: sim/cct_top_chk.sv */
// port assertions for the capture/compare block with timer routing
// assumes one clock domain and an apb access phase of one cycle
`default_nettype none

module cct_top_chk (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       sleep,
  input wire logic       adc_enabled,
  input wire logic [2:0] period_tick,
  input wire logic       counter_tick,
  input wire logic       conv_trigger,
  input wire logic       counter_reset,
  input wire logic [3:0] unit_timebase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  // --------------------------------
  // bus and event relations
  // --------------------------------
  ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
  error_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  trig_single_a: assert property (conv_trigger |=> !conv_trigger) else $error("trigger too long");
  trig_needs_adc_a: assert property (conv_trigger |-> $past(adc_enabled)) else $error("trigger, adc off");
  trig_awake_a: assert property (conv_trigger |-> !$past(sleep)) else $error("trigger while asleep");
  reset_after_tick_a: assert property (counter_reset |-> $past(counter_tick)) else $error("reset off edge");
  base_cause_a: assert property (|unit_timebase |-> |$past(period_tick)) else $error("stray timebase");

  // main scenarios reached
  cover property (conv_trigger);
  cover property (counter_reset);
  cover property (pslverr);
  cover property (|unit_timebase);
endmodule // cct_top_chk

bind cct_top cct_top_chk u_chk (
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .sleep(sleep), .adc_enabled(adc_enabled), .period_tick(period_tick),
  .counter_tick(counter_tick), .conv_trigger(conv_trigger), .counter_reset(counter_reset),
  .unit_timebase(unit_timebase)
);

`default_nettype wire

/* File: sim/cct_far.sv */
// model of the shared 16-bit counter on the far side of the block
// assumes the bench loads or stops it to place compare matches
`default_nettype none

module cct_far #(
  parameter int TICK_DIV = 8
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        counter_reset,
  output var  logic [15:0] wide_counter,
  output var  logic        counter_tick,
  output var  logic        overflow_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  int div_cnt;

  // --------------------------------
  // counter
  // --------------------------------
  // synchronous timer mode, stepped by a divided edge, never every clock
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 0;
      counter_tick <= 1'b0;
      wide_counter <= 16'h0000;
      overflow_flag <= 1'b0;
    end else begin
      counter_tick <= run && (div_cnt == TICK_DIV - 1);
      div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
      if (load)
        wide_counter <= load_val;
      else if (counter_reset)
        wide_counter <= 16'h0000;
      else if (counter_tick) begin
        wide_counter <= wide_counter + 16'h0001;
        if (wide_counter == 16'hffff)
          overflow_flag <= 1'b1; // only a true wrap flags
      end
    end
  end
endmodule // cct_far

`default_nettype wire

/* File: sim/tb_capture_compare_timer_select.sv */
// self-checking bench for the capture/compare block with timer routing
// assumes the far-side counter model and the register map of the header
`default_nettype none
`include "cct_defs.vh"

module tb_capture_compare_timer_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, resetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, last_err, conv_trigger, counter_reset, counter_tick, ovf;
  logic        sleep = 1'b0, adc_enabled = 1'b0, run = 1'b0, load = 1'b0;
  logic [2:0]  period_tick = 3'h0;
  logic [1:0]  pin_in = 2'h0, pin_out, pin_oe;
  logic [3:0]  unit_timebase;
  logic [15:0] load_val = 16'h0000, wide_counter;
  int          bad_count = 0, comparisons = 0;

  cct_top dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wide_counter(wide_counter), .counter_tick(counter_tick), .sleep(sleep),
    .adc_enabled(adc_enabled), .period_tick(period_tick), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .conv_trigger(conv_trigger), .counter_reset(counter_reset),
    .unit_timebase(unit_timebase));
  cct_far u_far (.clock(clock), .resetn(resetn), .run(run), .load(load), .load_val(load_val),
    .counter_reset(counter_reset), .wide_counter(wide_counter), .counter_tick(counter_tick),
    .overflow_flag(ovf));

  // --------------------------------
  // shared tasks
  // --------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until pready is sampled high, data taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic set_cnt(input logic [15:0] v);
    @(posedge clock);
    load <= 1'b1; load_val <= v;
    @(posedge clock);
    load <= 1'b0;
  endtask

  // slow enough that the two-flop sync and detector settle each half
  task automatic pulse_pin();
    @(posedge clock);
    pin_in[0] <= 1'b1;
    repeat (5) @(posedge clock);
    pin_in[0] <= 1'b0;
    repeat (5) @(posedge clock);
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs();
    rd(`CCT_OFF_TSEL); chk(rdat, 32'h0);
    wr(`CCT_OFF_TSEL, 32'hff);
    rd(`CCT_OFF_TSEL); chk(rdat, 32'hff);
    rd(12'h01c); chk(last_err, 32'h1);
    chk(rdat, 32'h0);
    $display("regs done");
  endtask

  task automatic t_route();
    logic [7:0] ts [2] = '{8'he4, 8'h1b};
    logic [3:0] e;
    for (int s = 0; s < 2; s++) begin
      wr(`CCT_OFF_TSEL, {24'h0, ts[s]});
      for (int i = 0; i < 3; i++) begin
        for (int k = 0; k < 4; k++) e[k] = (ts[s][2*k+:2] == i[1:0]);
        @(posedge clock) period_tick <= 3'h1 << i;
        @(posedge clock) period_tick <= 3'h0;
        #1 chk(unit_timebase, e);
      end
    end
    $display("route done");
  endtask

  task automatic t_capture();
    int n;
    for (int j = 0; j < 4; j++) begin
      n = (j < 2) ? 1 : (j == 2) ? 4 : 16;
      wr(`CCT_OFF_CTL1, 32'h0);
      wr(`CCT_OFF_CTL1, {28'h0, `CCT_M_CAP_FALL + j[3:0]});
      wr(`CCT_OFF_STAT, 32'h3);
      set_cnt(16'h1230 + j[15:0]);
      repeat (n - 1) pulse_pin();
      rd(`CCT_OFF_STAT); chk(rdat[0], 32'h0);
      pulse_pin();
      rd(`CCT_OFF_STAT); chk(rdat[0], 32'h1);
      rd(`CCT_OFF_VAL1); chk(rdat, 32'h1230 + j);
    end
    repeat (2) pulse_pin();
    wr(`CCT_OFF_CTL1, {28'h0, `CCT_M_CAP_4TH});
    wr(`CCT_OFF_STAT, 32'h3);
    repeat (2) pulse_pin();
    rd(`CCT_OFF_STAT);
    chk(rdat[0], 32'h1);
    wr(`CCT_OFF_CTL1, 32'h0);
    wr(`CCT_OFF_CTL1, {28'h0, `CCT_M_CAP_RISE});
    sleep <= 1'b1;
    set_cnt(16'h0aa5); pulse_pin();
    set_cnt(16'h055a); pulse_pin();
    sleep <= 1'b0;
    rd(`CCT_OFF_VAL1); chk(rdat, 32'h055a);
    rd(`CCT_OFF_STAT); chk(rdat[0], 32'h1);
    $display("capture done");
  endtask

  task automatic t_compare();
    logic [3:0] ms [4] = '{`CCT_M_SET, `CCT_M_CLEAR, `CCT_M_TOGGLE, `CCT_M_SWINT};
    logic       exp_o;
    exp_o = 1'b0;
    wr(`CCT_OFF_VAL1, 32'h0100);
    wr(`CCT_OFF_VAL2, 32'h0100);
    wr(`CCT_OFF_CTL2, {28'h0, `CCT_M_TOGGLE});
    for (int j = 0; j < 4; j++) begin
      set_cnt(16'h0000);
      wr(`CCT_OFF_CTL1, {28'h0, ms[j]});
      wr(`CCT_OFF_STAT, 32'h3);
      set_cnt(16'h0100);
      repeat (3) @(posedge clock);
      if (ms[j] == `CCT_M_SET) exp_o = 1'b1;
      if (ms[j] == `CCT_M_CLEAR) exp_o = 1'b0;
      if (ms[j] == `CCT_M_TOGGLE) exp_o = ~exp_o;
      #1 chk(pin_out, {~j[0], exp_o});
      chk(pin_oe, {1'b1, ms[j] != `CCT_M_SWINT});
      rd(`CCT_OFF_STAT); chk(rdat[0], 32'h1);
    end
    wr(`CCT_OFF_CTL1, 32'h0);
    @(posedge clock);
    #1 chk(pin_out[0], 32'h0);
    wr(`CCT_OFF_CTL1, {28'h0, `CCT_M_SWINT});
    set_cnt(16'h0000);
    wr(`CCT_OFF_STAT, 32'h3);
    sleep <= 1'b1;
    set_cnt(16'h0100);
    repeat (3) @(posedge clock);
    rd(`CCT_OFF_STAT); chk(rdat[0], 32'h0);
    sleep <= 1'b0;
    set_cnt(16'h0000);
    $display("compare done");
  endtask

  task automatic t_trig();
    int n;
    adc_enabled <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      wr(`CCT_OFF_CTL1, 32'h0);
      wr(`CCT_OFF_VAL1, 32'h0040);
      wr(`CCT_OFF_CTL1, {28'h0, `CCT_M_TRIG});
      set_cnt(16'h003e);
      run <= 1'b1;
      n = 0;
      do begin
        @(posedge clock);
        #1 n++;
      end while (conv_trigger !== 1'b1 && n < 100);
      chk(conv_trigger, 32'h1);
      chk(wide_counter, 32'h0040);
      chk(pin_oe[0], 32'h0);
      if (r == 1) wr(`CCT_OFF_VAL1, 32'h0080);
      n = 0;
      do begin
        @(posedge clock);
        #1 n++;
      end while (counter_reset !== 1'b1 && n < 14);
      chk(counter_reset, r == 0);
      @(posedge clock);
      #1 chk(wide_counter == 16'h0000, r == 0);
      chk(ovf, 32'h0);
      run <= 1'b0;
    end
    $display("trigger done");
  endtask

  // --------------------------------
  // sequence, watchdog and verdict
  // --------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_route();
    t_capture();
    t_compare();
    t_trig();
    complete_run();
  end

  // the whole sequence needs several hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    complete_run();
  end
endmodule // tb_capture_compare_timer_select

`default_nettype wire
